// [hw/lcmm_monitor.sv]
// lcmm_monitor: light curtain muting monitor with timed override
// assumes pins arrive asynchronously; register port is on clk
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module lcmm_monitor #(
  parameter int TICK_CYCLES = lcmm_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire lcmm_pkg::lcmm_pins_t pins,
  input wire logic [lcmm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic primary_safety_output,
  output logic override_aux_output,
  output logic muting_lamp,
  output logic fault_indicator,
  output logic test_source_a,
  output logic test_source_b
);
  import lcmm_pkg::*;

  lcmm_cfg_t cfg;
  lcmm_pins_t pin_meta, pin_s;
  lcmm_state_t state, next_state;
  logic [31:0] tick_cnt, ph_ms, ovr_ms, fclr_ms, ovr_lim;
  logic [31:0] sync_lim, mute_lim;
  logic [9:0] slow_ms, fast_ms;
  logic tick, blink_slow, blink_fast;
  logic [3:0] blk, used, blk_u, first_ok, a_bit, e_bit;
  logic [1:0] a, first_idx, exp2, want, oth, tp_ok, ovr_lvl;
  logic lc_blk, muted, permit_eff, mute_inf, lc_seen, lc_passed;
  logic sync_trip, perm_fault, any_fault, fault_off, clr_ok;
  logic ovr_req, ovr_req_d, ovr_active, ovr_seen, ovr_passed;
  logic fclr_d, clr_pulse, sync_over, mute_over;
  lcmm_tpair_t tp;

  ////////////////////////////////////////////////////////////////////////
  // register port: one config word, one status word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= CFG_RST;
    end else if (reg_wr && reg_addr == CFG_OFS) begin
      cfg <= lcmm_cfg_t'(reg_wdata[CFG_W-1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && reg_addr == CFG_OFS) begin
      reg_rdata <= {8'h00, cfg};
    end else if (reg_rd && reg_addr == STAT_OFS) begin
      reg_rdata <= {21'h00000, state, perm_fault, sync_trip, ovr_active,
        muted, primary_safety_output, override_aux_output, muting_lamp,
        fault_indicator};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only pin_s is read by logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= PIN_IDLE;
      pin_s <= PIN_IDLE;
    end else begin
      pin_meta <= pins;
      pin_s <= pin_meta;
    end
  end

  // sensors are normally closed: low means blocked
  assign blk = ~pin_s.mute_sensor_inputs;
  assign lc_blk = ~&pin_s.curtain_beam_input;
  assign used = (cfg.mode == MODE_FOUR) ? 4'hF : 4'h3;
  assign blk_u = blk & used;
  assign permit_eff = !cfg.permit_en || pin_s.mute_permit_input;

  ////////////////////////////////////////////////////////////////////////
  // 1 ms timebase shared by every interval timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 2));
      if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= 32'h0000_0000;
      end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slow_ms <= 10'h000;
      fast_ms <= 10'h000;
      blink_slow <= 1'b0;
      blink_fast <= 1'b0;
    end else if (tick) begin
      slow_ms <= (slow_ms == 10'(BLINK_SLOW_MS - 1)) ? 10'h000
        : slow_ms + 10'h001;
      fast_ms <= (fast_ms == 10'(BLINK_FAST_MS - 1)) ? 10'h000
        : fast_ms + 10'h001;
      if (slow_ms == 10'(BLINK_SLOW_MS - 1)) begin
        blink_slow <= !blink_slow;
      end
      if (fast_ms == 10'(BLINK_FAST_MS - 1)) begin
        blink_fast <= !blink_fast;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // override test pulses: the pulse must reach the input, else no request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_source_a <= 1'b1;
      test_source_b <= 1'b1;
      tp_ok <= 2'h0;
      ovr_lvl <= 2'h0;
    end else begin
      test_source_a <= !(cfg.ovr_pulse_test && tick_cnt < 32'(TP_LEN));
      test_source_b <= !(cfg.ovr_pulse_test && tick_cnt >= 32'(TP_LEN)
        && tick_cnt < 32'(2 * TP_LEN));
      if (tick_cnt == 32'(TP_LEN - 1)) begin
        tp_ok[0] <= !pin_s.override_request[0];
      end
      if (tick_cnt == 32'(2 * TP_LEN - 1)) begin
        tp_ok[1] <= !pin_s.override_request[1];
      end
      // level is held through the pulse windows so they cause no dropout
      if (!cfg.ovr_pulse_test || tick_cnt >= 32'(TP_QUIET)) begin
        ovr_lvl <= pin_s.override_request;
      end
    end
  end

  assign ovr_req = cfg.ovr_en && (&ovr_lvl)
    && (!cfg.ovr_pulse_test || (&tp_ok));
  assign ovr_lim = (cfg.ovr_time == 8'h00) ? 32'(OVR_ZERO_MS)
    : 32'(cfg.ovr_time) * 32'(OVR_STEP_MS);

  ////////////////////////////////////////////////////////////////////////
  // override period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovr_req_d <= 1'b0;
      ovr_active <= 1'b0;
      ovr_ms <= 32'h0000_0000;
    end else begin
      ovr_req_d <= ovr_req;
      if (!ovr_active) begin
        ovr_ms <= 32'h0000_0000;
        // only a fresh press while the output is off starts a period
        if (ovr_req && !ovr_req_d && !primary_safety_output) begin
          ovr_active <= 1'b1;
        end
      end else if (!ovr_req || ovr_ms >= ovr_lim) begin
        ovr_active <= 1'b0;
      end else if (tick) begin
        ovr_ms <= ovr_ms + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !ovr_active) begin
      ovr_seen <= 1'b0;
      ovr_passed <= 1'b0;
    end else begin
      ovr_seen <= ovr_seen || lc_blk || (|blk_u);
      if (ovr_seen && !lc_blk && blk_u == 4'h0) begin
        ovr_passed <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault clear input: high shorter than the limit, acts on falling edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fclr_d <= 1'b0;
      fclr_ms <= 32'h0000_0000;
      clr_pulse <= 1'b0;
    end else begin
      fclr_d <= pin_s.mute_fault_clear_input;
      clr_pulse <= fclr_d && !pin_s.mute_fault_clear_input
        && fclr_ms < 32'(FCLR_MAX_MS);
      if (!pin_s.mute_fault_clear_input) begin
        fclr_ms <= 32'h0000_0000;
      end else if (tick && fclr_ms < 32'(FCLR_MAX_MS)) begin
        fclr_ms <= fclr_ms + 32'h0000_0001;
      end
    end
  end

  // without a clear input the fault clears once the sensors are clear
  assign clr_ok = cfg.fault_clear_en ? clr_pulse : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // sequence timing
  assign tp = mute_pair(cfg.mute_time);
  assign mute_inf = (cfg.mute_time == MT_INF);
  assign mute_lim = tp.mute_s * 32'(MS_PER_S);
  assign sync_lim = tp.sync_s * 32'(MS_PER_S)
    + 32'(cfg.filter_x25) * 32'(FILTER_STEP_MS * FILTER_MULT);
  assign sync_over = !mute_inf && ph_ms >= sync_lim;
  assign mute_over = !mute_inf && ph_ms >= mute_lim;

  // first legal sensor and the one expected second
  assign first_ok = (cfg.mode == MODE_T) ? 4'h3
    : (cfg.mode == MODE_L) ? 4'h1 : 4'h9;
  assign first_idx = blk[0] ? 2'h0 : (cfg.mode == MODE_FOUR) ? 2'h3 : 2'h1;
  assign exp2 = (cfg.mode == MODE_L) ? 2'h1
    : (cfg.mode == MODE_FOUR) ? ((a == 2'h0) ? 2'h1 : 2'h2)
    : ((a == 2'h0) ? 2'h1 : 2'h0);
  // clearing order: T exits second-blocked first, L exits sensor 0 first
  assign want = (cfg.mode == MODE_L) ? a : exp2;
  assign oth = (cfg.mode == MODE_L) ? exp2 : a;
  assign a_bit = 4'(4'h1 << a);
  assign e_bit = 4'(4'h1 << exp2);
  assign muted = (state == ST_MUTED) || (state == ST_EXIT);
  assign lc_passed = lc_seen && !lc_blk;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (permit_eff && !lc_blk && blk_u != 4'h0) begin
          next_state = ((blk_u & ~first_ok) != 4'h0) ? ST_SEQ_FLT
            : ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (lc_blk) begin
          next_state = ST_SEQ_FLT;
        end else if (blk[exp2]) begin
          next_state = ST_MUTED;
        end else if ((blk_u & ~a_bit) != 4'h0) begin
          next_state = ST_SEQ_FLT;
        end else if (!blk[a]) begin
          next_state = ST_IDLE;
        end else if (sync_over) begin
          next_state = ST_SYNC_FLT;
        end
      end
      ST_MUTED: begin
        if (mute_over && !lc_passed) begin
          next_state = ST_SEQ_FLT;
        end else if (blk_u == 4'h0 && !lc_blk) begin
          next_state = ST_IDLE;
        end else if (cfg.mode == MODE_FOUR) begin
          next_state = ST_MUTED;
        end else if (lc_passed && !blk[want] && blk[oth]) begin
          next_state = ST_EXIT;
        end else if (lc_passed && blk[want] && !blk[oth]) begin
          next_state = ST_SEQ_FLT;
        end else if (!lc_seen && !blk[exp2] && blk[a]) begin
          next_state = ST_FIRST;
        end else if (!lc_seen && blk[exp2] && !blk[a]) begin
          next_state = ST_SEQ_FLT;
        end
      end
      ST_EXIT: begin
        if (lc_blk || blk[want]) begin
          next_state = ST_SEQ_FLT;
        end else if (!blk[oth]) begin
          next_state = ST_IDLE;
        end else if (sync_over) begin
          next_state = ST_SYNC_FLT;
        end
      end
      ST_SYNC_FLT: begin
        // backing away clears it; after a trip only an override does
        if (blk_u == 4'h0 && !lc_blk && (!sync_trip || ovr_active)) begin
          next_state = ST_IDLE;
        end
      end
      ST_SEQ_FLT: begin
        if (blk_u == 4'h0 && !lc_blk && (ovr_active || clr_ok)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      a <= 2'h0;
      ph_ms <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_FIRST) begin
        a <= first_idx;
      end
      if (next_state != state) begin
        ph_ms <= 32'h0000_0000;
      end else if (tick) begin
        ph_ms <= ph_ms + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lc_seen <= 1'b0;
      sync_trip <= 1'b0;
      perm_fault <= 1'b0;
    end else begin
      if (next_state == ST_MUTED && state != ST_MUTED) begin
        lc_seen <= 1'b0;
      end else if (state == ST_MUTED && lc_blk) begin
        lc_seen <= 1'b1;
      end
      if (state == ST_SYNC_FLT && lc_blk) begin
        sync_trip <= 1'b1;
      end else if (state != ST_SYNC_FLT) begin
        sync_trip <= 1'b0;
      end
      // set and clear are exclusive: set needs a blocked sensor
      if (state == ST_IDLE && !permit_eff && blk_u != 4'h0) begin
        perm_fault <= 1'b1;
      end else if (blk_u == 4'h0 && clr_ok) begin
        perm_fault <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign fault_off = (state == ST_SEQ_FLT) || sync_trip;
  assign any_fault = (state == ST_SEQ_FLT) || (state == ST_SYNC_FLT)
    || perm_fault;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primary_safety_output <= 1'b0;
      override_aux_output <= 1'b0;
      muting_lamp <= 1'b0;
      fault_indicator <= 1'b0;
    end else begin
      // permit fault alone never cuts the output
      primary_safety_output <= ovr_active
        || (!fault_off && (!lc_blk || muted));
      override_aux_output <= ovr_active && cfg.ovr_o2_en
        && !(cfg.exit_ends_ovr && ovr_passed);
      muting_lamp <= ovr_active ? blink_fast
        : any_fault ? blink_slow : muted;
      fault_indicator <= any_fault && blink_slow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence ovr_granted;
    !primary_safety_output ##1 $rose(ovr_active);
  endsequence

  seq_trip_a:
    assert property (state == ST_SEQ_FLT && !ovr_active
      |=> !primary_safety_output)
    else $error("safety output on during sequence fault");
  aux_opt_a:
    assert property ($rose(ovr_active) && cfg.ovr_o2_en |=> override_aux_output)
    else $error("aux output missing at override start");
  ovr_on_a:
    assert property (ovr_granted ##1 ovr_active
      |-> primary_safety_output [*2])
    else $error("override did not drive safety output");
  ovr_end_a:
    assert property (ovr_active && !ovr_req |=> !ovr_active ##1 !ovr_active)
    else $error("override outlived its request");
  ovr_ignore_a:
    assert property (primary_safety_output && !ovr_active |=> !ovr_active)
    else $error("override accepted while output on");
  ovr_limit_a:
    assert property (ovr_active |-> ovr_ms <= ovr_lim)
    else $error("override ran past its limit");
  permit_a:
    assert property (state == ST_IDLE && !permit_eff |=> state != ST_FIRST)
    else $error("muting began without permit");
  curtain_a:
    assert property (lc_blk && !muted && !ovr_active |=> !primary_safety_output)
    else $error("blocked curtain left output on");
  clr_pulse_a:
    assert property (clr_pulse |-> $past(fclr_ms) < 32'(FCLR_MAX_MS))
    else $error("fault clear from an over-long pulse");
  sync_win_a:
    assert property ((state == ST_FIRST || state == ST_EXIT) && !mute_inf
      |-> ph_ms <= sync_lim)
    else $error("sync window exceeded without fault");
  lamp_mute_a:
    assert property (muted && !any_fault && !ovr_active |=> muting_lamp)
    else $error("lamp dark while muted");

endmodule : lcmm_monitor

// [shared/lcmm_pkg.sv]
// lcmm_pkg: constants and types shared by the light curtain muting monitor
// assumes a 100 MHz clock and a 1 ms timebase derived from it
package lcmm_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int TIMEBASE_MS = 1;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES_DEF = CLK_HZ / MS_PER_S * TIMEBASE_MS;

  // override, fault clear, filter and lamp timing
  localparam int OVR_STEP_S = 5;
  localparam int OVR_STEP_MS = OVR_STEP_S * MS_PER_S;
  localparam int OVR_ZERO_MS = 500;
  localparam int FCLR_MAX_S = 3;
  localparam int FCLR_MAX_MS = FCLR_MAX_S * MS_PER_S;
  localparam int FILTER_STEP_MS = 25;
  localparam int FILTER_MULT = 2;
  localparam int BLINK_SLOW_HZ = 1;
  localparam int BLINK_FAST_HZ = 3;
  localparam int BLINK_SLOW_MS = MS_PER_S / (2 * BLINK_SLOW_HZ);
  localparam int BLINK_FAST_MS = MS_PER_S / (2 * BLINK_FAST_HZ);

  // override test pulses: A window, then B window, then settle
  localparam int TP_LEN = 16;
  localparam int TP_SETTLE = 8;
  localparam int TP_QUIET = 2 * TP_LEN + TP_SETTLE;

  // register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CFG_W = 24;

  typedef enum logic [1:0] {MODE_T, MODE_L, MODE_FOUR} lcmm_mode_t;
  typedef enum logic [3:0] {
    MT_10S, MT_20S, MT_30S, MT_60S, MT_300S, MT_900S,
    MT_1800S, MT_3600S, MT_28800S, MT_INF
  } lcmm_mtime_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_MUTED, ST_EXIT, ST_SYNC_FLT, ST_SEQ_FLT
  } lcmm_state_t;

  typedef struct packed {
    lcmm_mode_t mode;
    lcmm_mtime_t mute_time;
    logic [3:0] filter_x25;
    logic ovr_en;
    logic ovr_o2_en;
    logic exit_ends_ovr;
    logic [7:0] ovr_time;
    logic ovr_pulse_test;
    logic permit_en;
    logic fault_clear_en;
  } lcmm_cfg_t;

  typedef struct packed {
    logic [1:0] curtain_beam_input;
    logic [3:0] mute_sensor_inputs;
    logic [1:0] override_request;
    logic mute_permit_input;
    logic mute_fault_clear_input;
  } lcmm_pins_t;

  typedef struct packed {
    logic [31:0] mute_s;
    logic [31:0] sync_s;
  } lcmm_tpair_t;

  localparam lcmm_cfg_t CFG_RST = '{MODE_T, MT_10S, 4'h0, 1'b1, 1'b1,
    1'b1, 8'h01, 1'b0, 1'b0, 1'b1};
  localparam lcmm_pins_t PIN_IDLE = '{2'h3, 4'hF, 2'h0, 1'b1, 1'b0};

  // linked muting and synchronisation times, in seconds
  function automatic lcmm_tpair_t mute_pair(lcmm_mtime_t sel);
    case (sel)
      MT_10S: return '{32'd10, 32'd3};
      MT_20S: return '{32'd20, 32'd3};
      MT_30S: return '{32'd30, 32'd3};
      MT_60S: return '{32'd60, 32'd6};
      MT_300S: return '{32'd300, 32'd30};
      MT_900S: return '{32'd900, 32'd90};
      MT_1800S: return '{32'd1800, 32'd180};
      MT_3600S: return '{32'd3600, 32'd180};
      MT_28800S: return '{32'd28800, 32'd180};
      default: return '{32'h0, 32'h0};
    endcase
  endfunction : mute_pair

endpackage : lcmm_pkg

// [sim/lcmm_field.sv]
// lcmm_field: behavioural sensors, curtain, override switch and clear button
// assumes the bench calls its tasks; pins change just after a rising edge
`timescale 1ns/1ps
module lcmm_field #(
  parameter int TICK = 41
) (
  input wire logic clk,
  input wire logic test_source_a,
  input wire logic test_source_b,
  output lcmm_pkg::lcmm_pins_t pins
);
  import lcmm_pkg::*;
  // built-in terminals: the smaller of the two minimum gaps applies
  localparam int GAP_MS = 50;
  // the curtain only has to settle; it has no spacing rule of its own
  localparam int SETTLE_MS = 5;
  lcmm_pins_t drv;

  initial drv = PIN_IDLE;

  // a closed override contact passes its test source through to the input
  always_comb begin
    pins = drv;
    pins.override_request = drv.override_request
      & {test_source_b, test_source_a};
  end

  task automatic wait_ms(input int n);
    repeat (n * TICK) @(posedge clk);
  endtask : wait_ms

  ////////////////////////////////////////////////////////////////////////////
  task automatic sensor(input int idx, input logic lvl);
    @(posedge clk);
    drv.mute_sensor_inputs[idx] <= lvl;
    wait_ms(GAP_MS);
  endtask : sensor

  task automatic curtain(input logic [1:0] lvl);
    @(posedge clk);
    drv.curtain_beam_input <= lvl;
    wait_ms(SETTLE_MS);
  endtask : curtain

  // both channels move together, as a two-contact switch would
  task automatic press(input logic on);
    @(posedge clk);
    drv.override_request <= {2{on}};
    repeat (10) @(posedge clk);
  endtask : press

  // short press: falling edge well inside the accepted width
  task automatic pulse_clear();
    @(posedge clk);
    drv.mute_fault_clear_input <= 1'h1;
    wait_ms(10);
    drv.mute_fault_clear_input <= 1'h0;
    repeat (10) @(posedge clk);
  endtask : pulse_clear

  // mute permit level, held until changed again
  task automatic permit(input logic on);
    @(posedge clk);
    drv.mute_permit_input <= on;
    repeat (10) @(posedge clk);
  endtask : permit
endmodule : lcmm_field

// [sim/lcmm_monitor_tb.sv]
// lcmm_monitor_tb: self-checking bench for the muting monitor
// assumes lcmm_field stands in for everything outside the relay
`timescale 1ns/1ps
module lcmm_monitor_tb;
  import lcmm_pkg::*;
  // short tick keeps the 500 ms override near 20k cycles
  localparam int TICK = 41;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  lcmm_pins_t pins;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic prim, aux, lamp, flt, tsa, tsb;
  int error_cnt = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  lcmm_field #(.TICK(TICK)) field (
    .clk(clk), .test_source_a(tsa), .test_source_b(tsb), .pins(pins)
  );

  lcmm_monitor #(.TICK_CYCLES(TICK)) dut (
    .clk(clk), .sys_rst(sys_rst), .pins(pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .primary_safety_output(prim),
    .override_aux_output(aux), .muting_lamp(lamp), .fault_indicator(flt),
    .test_source_a(tsa), .test_source_b(tsb)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_word

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  // data stand only in the cycle after the strobe edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : reg_read

  // curtain blocked while only one sensor is: the sequence fault latches
  task automatic trip();
    field.sensor(0, 1'h0);
    field.curtain(2'h1);
    chk_bit("safety out on trip", 1'h0, prim);
    field.curtain(2'h3);
    field.sensor(0, 1'h1);
  endtask : trip

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    repeat (16) @(posedge clk);
    #1 chk_bit("safety out in reset", 1'h0, prim);
    chk_bit("aux in reset", 1'h0, aux);
    @(posedge clk);
    sys_rst <= 1'h0;
    reg_read(CFG_OFS, d);
    chk_word("config at reset", {8'h00, CFG_RST}, d);
    reg_read(8'hFC, d);
    chk_word("unmapped read", 32'h0, d);
    repeat (10) @(posedge clk);
    chk_bit("safety out clear", 1'h1, prim);
    chk_bit("test source a idle", 1'h1, tsa);
    chk_bit("test source b idle", 1'h1, tsb);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ignored();
    field.press(1'h1);
    chk_bit("aux while on", 1'h0, aux);
    chk_bit("safety out held", 1'h1, prim);
    field.press(1'h0);
    $display("test ignored override done");
  endtask : t_ignored

  task automatic t_pass();
    for (int i = 0; i < 2; i++) begin
      field.sensor(i, 1'h0);
      field.sensor(1 - i, 1'h0);
      chk_bit("lamp when muted", 1'h1, lamp);
      field.curtain(2'h2);
      chk_bit("safety out muted", 1'h1, prim);
      field.curtain(2'h3);
      field.sensor(1 - i, 1'h1);
      field.sensor(i, 1'h1);
      chk_bit("lamp after exit", 1'h0, lamp);
      chk_bit("safety out after exit", 1'h1, prim);
    end
    $display("test passage done");
  endtask : t_pass

  task automatic t_trip();
    logic [31:0] d;
    logic b;
    trip();
    reg_read(STAT_OFS, d);
    chk_word("status primary bit", 32'h0, d & 32'h8);
    chk_word("status state", {21'h0, ST_SEQ_FLT, 8'h00}, d & 32'h700);
    // one whole half period later the indicator must show the other level
    b = flt;
    field.wait_ms(BLINK_SLOW_MS);
    chk_bit("fault indicator", !b, flt);
    $display("test trip done");
  endtask : t_trip

  task automatic t_override();
    lcmm_cfg_t c;
    logic b;
    c = CFG_RST;
    c.ovr_time = 8'h00;
    reg_write(CFG_OFS, {8'h00, c});
    field.press(1'h1);
    chk_bit("safety out override", 1'h1, prim);
    chk_bit("aux override", 1'h1, aux);
    b = lamp;
    field.wait_ms(BLINK_FAST_MS);
    chk_bit("lamp override blink", !b, lamp);
    field.wait_ms(OVR_ZERO_MS - 10 - BLINK_FAST_MS);
    chk_bit("aux before limit", 1'h1, aux);
    field.wait_ms(20);
    chk_bit("aux after limit", 1'h0, aux);
    field.press(1'h0);
    reg_write(CFG_OFS, {8'h00, CFG_RST});
    $display("test override time done");
  endtask : t_override

  // override inputs pulse tested: the switch must pass both test sources
  task automatic t_release();
    lcmm_cfg_t c;
    c = CFG_RST;
    c.ovr_pulse_test = 1'h1;
    trip();
    reg_write(CFG_OFS, {8'h00, c});
    field.press(1'h1);
    field.wait_ms(2);
    chk_bit("aux pressed", 1'h1, aux);
    field.press(1'h0);
    field.wait_ms(2);
    chk_bit("aux released", 1'h0, aux);
    reg_write(CFG_OFS, {8'h00, CFG_RST});
    $display("test release done");
  endtask : t_release

  task automatic t_fclr();
    trip();
    chk_bit("safety out held by fault", 1'h0, prim);
    field.pulse_clear();
    chk_bit("safety out after clear", 1'h1, prim);
    $display("test fault clear done");
  endtask : t_fclr

  // reverse travel from the last sensor, no time limits
  task automatic t_four();
    lcmm_cfg_t c;
    c = CFG_RST;
    c.mode = MODE_FOUR;
    c.mute_time = MT_INF;
    c.filter_x25 = 4'h1;
    reg_write(CFG_OFS, {8'h00, c});
    field.sensor(3, 1'h0);
    field.sensor(2, 1'h0);
    chk_bit("lamp four sensor", 1'h1, lamp);
    field.curtain(2'h2);
    chk_bit("safety out four sensor", 1'h1, prim);
    field.curtain(2'h3);
    field.sensor(3, 1'h1);
    field.sensor(2, 1'h1);
    chk_bit("lamp after four sensor", 1'h0, lamp);
    reg_write(CFG_OFS, {8'h00, CFG_RST});
    $display("test four sensor done");
  endtask : t_four

  // permit low, no clear input: the fault goes once the sensor is clear
  task automatic t_permit();
    lcmm_cfg_t c;
    logic [31:0] d;
    c = CFG_RST;
    c.permit_en = 1'h1;
    c.fault_clear_en = 1'h0;
    reg_write(CFG_OFS, {8'h00, c});
    field.permit(1'h0);
    field.sensor(0, 1'h0);
    reg_read(STAT_OFS, d);
    chk_word("permit fault set", 32'h80, d & 32'h80);
    chk_bit("safety out permit fault", 1'h1, prim);
    field.curtain(2'h1);
    chk_bit("safety out unpermitted", 1'h0, prim);
    field.curtain(2'h3);
    chk_bit("safety out curtain clear", 1'h1, prim);
    field.sensor(0, 1'h1);
    reg_read(STAT_OFS, d);
    chk_word("permit fault cleared", 32'h0, d & 32'h80);
    field.permit(1'h1);
    reg_write(CFG_OFS, {8'h00, CFG_RST});
    $display("test mute permit done");
  endtask : t_permit

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_ignored();
    t_pass();
    t_trip();
    t_override();
    t_release();
    t_fclr();
    t_four();
    t_permit();
    tally_and_finish();
  end

  // about 86k cycles expected; the limit keeps the run inside its budget
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : lcmm_monitor_tb
